// ==== design/ebf_host.v ====
// Pin controller that drives an elastic bubble FIFO device.
// Assumes the device pins are wired straight to the ports below and that
// the device flags and read word are asynchronous to clk_in.
`timescale 1ns/10ps
`default_nettype none
`include "ebf_defs.vh"

module ebf_host #(
  parameter WIDTH      = `EBF_WIDTH,
  parameter DEPTH      = `EBF_DEPTH,
  parameter STROBE_CYC = `EBF_STROBE_CYC,
  parameter CLEAR_CYC  = `EBF_CLEAR_CYC,
  parameter SETTLE_CYC = `EBF_SETTLE_CYC
) (
  // Clock and reset
  input  wire             clk_in,
  input  wire             rst_in,
  // User write side
  input  wire             wr_valid_in,
  input  wire [WIDTH-1:0] wr_data_in,
  output wire             wr_ready_out,
  // User read side
  input  wire             rd_ready_in,
  output reg  [WIDTH-1:0] rd_data_out,
  output reg              rd_valid_out,
  // User control and status
  input  wire             clear_req_in,
  output reg              clear_busy_out,
  output reg  [4:0]       level_out,
  // Device pins
  output reg              master_clear_out,
  output reg              push_strobe_out,
  output reg  [WIDTH-1:0] write_word_out,
  output reg              pop_strobe_out,
  output reg              read_enable_n_out,
  input  wire             input_ready_in,
  input  wire             output_valid_flag_in,
  input  wire [WIDTH-1:0] read_word_in
);

  localparam [3:0] W_IDLE  = 4'h1;
  localparam [3:0] W_SETUP = 4'h2;
  localparam [3:0] W_HIGH  = 4'h4;
  localparam [3:0] W_LOW   = 4'h8;
  localparam [2:0] R_IDLE  = 3'h1;
  localparam [2:0] R_HIGH  = 3'h2;
  localparam [2:0] R_LOW   = 3'h4;
  localparam [`EBF_CNT_W-1:0] STROBE_N = STROBE_CYC;
  localparam [`EBF_CNT_W-1:0] CLEAR_N  = CLEAR_CYC;
  localparam [`EBF_CNT_W-1:0] SETTLE_N = SETTLE_CYC;
  localparam [4:0]            FULL_N   = DEPTH;

  reg  [3:0]            wstate;
  reg  [2:0]            rstate;
  reg  [`EBF_CNT_W-1:0] wcnt;
  reg  [`EBF_CNT_W-1:0] rcnt;
  reg  [`EBF_CNT_W-1:0] ccnt;
  wire [WIDTH+1:0]      pins_sync;
  wire                  ready_sync;
  wire                  valid_sync;
  wire [WIDTH-1:0]      word_sync;
  wire                  push_take;
  wire                  pop_take;

  // Flags and read word cross into clk_in before anything reads them
  ebf_sync #(
    .WIDTH    (WIDTH + 2)
  ) u_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .async_in ({input_ready_in, output_valid_flag_in, read_word_in}),
    .sync_out (pins_sync)
  );

  assign ready_sync = pins_sync[WIDTH+1];
  assign valid_sync = pins_sync[WIDTH];
  assign word_sync  = pins_sync[WIDTH-1:0];

  // Push only on a seen ready flag and with room by our own count
  assign push_take = (wstate == W_IDLE) && !clear_busy_out && wr_valid_in &&
                     ready_sync && (level_out != FULL_N);
  // Strobe is never held high against a full device; it waits for room
  assign wr_ready_out = (wstate == W_IDLE) && !clear_busy_out &&
                        ready_sync && (level_out != FULL_N);
  // Pop only when the device shows a valid word at its outputs
  assign pop_take = (rstate == R_IDLE) && !clear_busy_out && rd_ready_in &&
                    valid_sync;

  // Master clear pulse after reset and on user request
  always @(posedge clk_in) begin
    if (rst_in) begin
      clear_busy_out   <= 1'b1;
      master_clear_out <= 1'b1;
      ccnt             <= CLEAR_N;
    end else if (clear_req_in) begin
      clear_busy_out   <= 1'b1;
      master_clear_out <= 1'b1;
      ccnt             <= CLEAR_N;
    end else if (ccnt != {`EBF_CNT_W{1'b0}}) begin
      ccnt <= ccnt - 1'b1;
      if (ccnt == 8'h01) begin
        master_clear_out <= 1'b0;
      end
    end else begin
      // Settle gap lets the synchronised flags reflect the cleared device
      master_clear_out <= 1'b0;
      clear_busy_out   <= 1'b0;
    end
  end

  // Writer: setup, strobe high, strobe low, then wait for flags to settle
  always @(posedge clk_in) begin
    if (rst_in || clear_busy_out) begin
      // Strobe kept low across clear so no word loads as clear falls
      wstate          <= W_IDLE;
      wcnt            <= {`EBF_CNT_W{1'b0}};
      push_strobe_out <= 1'b0;
      write_word_out  <= {WIDTH{1'b0}};
    end else begin
      case (wstate)
        W_IDLE: begin
          if (push_take) begin
            write_word_out <= wr_data_in;
            wcnt           <= STROBE_N;
            wstate         <= W_SETUP;
          end
        end
        W_SETUP: begin
          if (wcnt == 8'h01) begin
            push_strobe_out <= 1'b1;
            wcnt            <= STROBE_N;
            wstate          <= W_HIGH;
          end else begin
            wcnt <= wcnt - 1'b1;
          end
        end
        W_HIGH: begin
          if (wcnt == 8'h01) begin
            // Falling edge releases the word to ripple onward
            push_strobe_out <= 1'b0;
            wcnt            <= SETTLE_N;
            wstate          <= W_LOW;
          end else begin
            wcnt <= wcnt - 1'b1;
          end
        end
        W_LOW: begin
          // Ready flag may still show its old value until this runs out
          if (wcnt == 8'h01) begin
            wstate <= W_IDLE;
          end else begin
            wcnt <= wcnt - 1'b1;
          end
        end
        default: begin
          wstate          <= W_IDLE;
          push_strobe_out <= 1'b0;
        end
      endcase
    end
  end

  // Reader: take the word, strobe high, fall to pop, then settle
  always @(posedge clk_in) begin
    if (rst_in || clear_busy_out) begin
      rstate         <= R_IDLE;
      rcnt           <= {`EBF_CNT_W{1'b0}};
      pop_strobe_out <= 1'b0;
      rd_valid_out   <= 1'b0;
    end else begin
      rd_valid_out <= 1'b0;
      case (rstate)
        R_IDLE: begin
          if (pop_take) begin
            rd_valid_out   <= 1'b1;
            pop_strobe_out <= 1'b1;
            rcnt           <= STROBE_N;
            rstate         <= R_HIGH;
          end
        end
        R_HIGH: begin
          if (rcnt == 8'h01) begin
            pop_strobe_out <= 1'b0;
            rcnt           <= SETTLE_N;
            rstate         <= R_LOW;
          end else begin
            rcnt <= rcnt - 1'b1;
          end
        end
        R_LOW: begin
          if (rcnt == 8'h01) begin
            rstate <= R_IDLE;
          end else begin
            rcnt <= rcnt - 1'b1;
          end
        end
        default: begin
          rstate         <= R_IDLE;
          pop_strobe_out <= 1'b0;
        end
      endcase
    end
  end

  // Read data holds the last taken word, even through a clear
  always @(posedge clk_in) begin
    if (rst_in) begin
      rd_data_out <= {WIDTH{1'b0}};
    end else if (pop_take) begin
      rd_data_out <= word_sync;
    end
  end

  // Words held in the device, by our own count of pushes and pops
  always @(posedge clk_in) begin
    if (rst_in || clear_busy_out) begin
      level_out <= 5'h00;
    end else if (push_take && !pop_take) begin
      level_out <= level_out + 5'h01;
    end else if (pop_take && !push_take) begin
      level_out <= level_out - 5'h01;
    end
  end

  // Read outputs stay enabled except while the device is being cleared
  always @(posedge clk_in) begin
    if (rst_in) begin
      read_enable_n_out <= 1'b1;
    end else begin
      read_enable_n_out <= clear_busy_out;
    end
  end

endmodule

`default_nettype wire

// ==== design/ebf_sync.v ====
// Two flip-flop synchroniser for a bundle of asynchronous pin inputs.
// Assumes the inputs are levels from outside the clk_in domain.
`timescale 1ns/10ps
`default_nettype none

module ebf_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input  wire             clk_in,
  input  wire             rst_in,
  // Asynchronous level in, synchronised level out
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always @(posedge clk_in) begin
    if (rst_in) begin
      meta     <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

`default_nettype wire

// ==== pkg/ebf_defs.vh ====
// Timing constants for the elastic bubble FIFO pin controller.
// Assumes a single 200 MHz system clock and one attached FIFO device.
`ifndef EBF_DEFS_VH
`define EBF_DEFS_VH

`define EBF_WIDTH        4
`define EBF_DEPTH        16
`define EBF_CLK_NS       5
// Least high/low time of a strobe and of data setup ahead of it
`define EBF_STROBE_NS    20
// Least master clear pulse width
`define EBF_CLEAR_NS     50
// Wait after a strobe edge for device flags to respond and pass the synchroniser
`define EBF_SETTLE_NS    40
`define EBF_STROBE_CYC   ((`EBF_STROBE_NS + `EBF_CLK_NS - 1) / `EBF_CLK_NS)
`define EBF_CLEAR_CYC    ((`EBF_CLEAR_NS + `EBF_CLK_NS - 1) / `EBF_CLK_NS)
`define EBF_SETTLE_CYC   ((`EBF_SETTLE_NS + `EBF_CLK_NS - 1) / `EBF_CLK_NS)
`define EBF_CNT_W        8

`endif

// ==== testbench/ebf_dev_model.sv ====
// Behavioural model of the sixteen word elastic FIFO device.
// Assumes a controller that clears it before use; ripple is a fixed delay.
`timescale 1ns/10ps
`default_nettype none
module ebf_dev_model (
  // Strobes and controls
  input  wire logic       master_clear_in,
  input  wire logic       push_strobe_in,
  input  wire logic       pop_strobe_in,
  input  wire logic       read_enable_n_in,
  input  wire logic [3:0] write_word_in,
  // Flags and data
  output var  logic       input_ready_out,
  output var  logic       output_valid_flag_out,
  output wire logic [3:0] read_word_out
);
  logic [3:0] words[$];
  logic [3:0] out_stage = 4'h9;         // Power-up content is arbitrary
  logic [3:0] stage_word;
  logic       stage_busy = 1'b0;
  initial {input_ready_out, output_valid_flag_out} = 2'b00;
  // Clear empties the store but keeps the output stage word
  always @(posedge master_clear_in) begin
    words.delete();
    input_ready_out = 1'b1;
    output_valid_flag_out = 1'b0;
  end
  // Capture, then hold in stage until the strobe falls. Delays sit off
  // the 5 ns clock grid so flag changes never race a sampling edge.
  task automatic load_stage;
    stage_word = write_word_in;
    stage_busy = 1'b1;
    #4 input_ready_out = 1'b0;
    @(negedge push_strobe_in);
    #31 words.push_back(stage_word);
    stage_busy = 1'b0;
    input_ready_out = (words.size() < 16);
    if (words.size() == 1) begin
      out_stage = words[0];
      output_valid_flag_out = 1'b1;
    end
  endtask
  always @(posedge push_strobe_in)
    if (input_ready_out && !master_clear_in) load_stage();
  // A strobe already high when clear ends loads its word then
  always @(negedge master_clear_in)
    if (push_strobe_in) load_stage();
  // Falling pop drops valid, then the next word ripples down
  always @(negedge pop_strobe_in) if (output_valid_flag_out) begin
    #4 output_valid_flag_out = 1'b0;
    void'(words.pop_front());
    #30 input_ready_out = !stage_busy && (words.size() < 16);
    if (words.size() > 0) begin
      out_stage = words[0];
      output_valid_flag_out = 1'b1;
    end
  end
  assign read_word_out = read_enable_n_in ? 4'hZ : out_stage;
endmodule
`default_nettype wire

// ==== testbench/ebf_host_properties.sv ====
// Concurrent checks on the pin side of the FIFO pin controller.
// Assumes the bench sets STROBE_CYC=2, CLEAR_CYC=2 and SETTLE_CYC=4.
`timescale 1ns/10ps
`default_nettype none
module ebf_host_properties (
  // Clock and reset
  input wire logic       clk_in,
  input wire logic       rst_in,
  // Watched ports
  input wire logic       master_clear_out,
  input wire logic       push_strobe_out,
  input wire logic       pop_strobe_out,
  input wire logic       clear_busy_out,
  input wire logic [4:0] level_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Strobes are cut one edge after a clear starts, so look one cycle late
  property p_quiet;
    $past(clear_busy_out) |-> !push_strobe_out && !pop_strobe_out;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("strobe while clearing");
  property p_clr_wide;
    $fell(master_clear_out) |-> $past(master_clear_out, 2);
  endproperty
  a_clr_wide: assert property (p_clr_wide)
    else $error("clear too short");
  // A push only ever follows a counted word and never overfills
  property p_room;
    $rose(push_strobe_out) |-> level_out != 5'h00 && level_out <= 5'h10;
  endproperty
  a_room: assert property (p_room)
    else $error("push beyond capacity");
  property p_push;
    $rose(push_strobe_out) |-> push_strobe_out[*2] ##1 !push_strobe_out;
  endproperty
  a_push: assert property (p_push)
    else $error("push strobe width");
  // Gap covers settle plus flag sync, so the next push sees a fresh ready
  property p_gap;
    $fell(push_strobe_out) |-> !push_strobe_out[*6];
  endproperty
  a_gap: assert property (p_gap)
    else $error("push gap too short");
  property p_pop;
    $rose(pop_strobe_out) |-> pop_strobe_out[*2] ##1 !pop_strobe_out[*4];
  endproperty
  a_pop: assert property (p_pop)
    else $error("pop strobe shape");
endmodule
`default_nettype wire

// ==== testbench/ebf_host_tb.sv ====
// Self-checking bench for the FIFO pin controller and a device model.
// Assumes shortened strobe, clear and settle counts for a quick run.
`timescale 1ns/10ps
`default_nettype none
module ebf_host_tb;
  logic       clk_in, rst_in, wr_valid_in, rd_ready_in, clear_req_in;
  logic [3:0] wr_data_in;
  wire        wr_ready_out, rd_valid_out, clear_busy_out, mc, ps, pp, oen, ir, ov;
  wire  [3:0] rd_data_out, ww, rw;
  wire  [4:0] level_out;
  int         mismatches = 0;
  int         checks = 0;
  ebf_host #(.STROBE_CYC(2), .CLEAR_CYC(2), .SETTLE_CYC(4)) dut_u (
    .clk_in(clk_in), .rst_in(rst_in), .wr_valid_in(wr_valid_in),
    .wr_data_in(wr_data_in), .wr_ready_out(wr_ready_out),
    .rd_ready_in(rd_ready_in), .rd_data_out(rd_data_out),
    .rd_valid_out(rd_valid_out), .clear_req_in(clear_req_in),
    .clear_busy_out(clear_busy_out), .level_out(level_out),
    .master_clear_out(mc), .push_strobe_out(ps), .write_word_out(ww),
    .pop_strobe_out(pp), .read_enable_n_out(oen), .input_ready_in(ir),
    .output_valid_flag_in(ov), .read_word_in(rw));
  ebf_dev_model dev_u (.master_clear_in(mc), .push_strobe_in(ps),
    .pop_strobe_in(pp), .read_enable_n_in(oen), .write_word_in(ww),
    .input_ready_out(ir), .output_valid_flag_out(ov), .read_word_out(rw));
  // Clock at 200 MHz
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  task chk(input string nm, input logic [4:0] got, input logic [4:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task give_verdict;
    if (mismatches == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Hold a word until the controller takes it
  task put(input logic [3:0] w);
    @(posedge clk_in);
    wr_valid_in <= 1'b1;
    wr_data_in <= w;
    @(negedge clk_in);
    while (wr_ready_out !== 1'b1) @(negedge clk_in);
    @(posedge clk_in);
    wr_valid_in <= 1'b0;
  endtask
  task get(input logic [3:0] w);
    @(posedge clk_in);
    rd_ready_in <= 1'b1;
    @(negedge clk_in);
    while (rd_valid_out !== 1'b1) @(negedge clk_in);
    chk("rd_data", {1'b0, rd_data_out}, {1'b0, w});
    @(posedge clk_in);
    rd_ready_in <= 1'b0;
  endtask
  // Fill to capacity, see refusal, then drain in order
  task t_fill_drain;
    for (int i = 0; i < 16; i++) put(4'(i ^ 5));
    repeat (40) @(negedge clk_in);
    chk("level", level_out, 5'h10);
    chk("wr_ready", {4'h0, wr_ready_out}, 5'h00);
    chk("dev_ready", {4'h0, ir}, 5'h00);
    for (int i = 0; i < 16; i++) get(4'(i ^ 5));
    repeat (40) @(negedge clk_in);
    chk("valid_empty", {4'h0, ov}, 5'h00);
    chk("held_word", {1'b0, rw}, 5'h0A);
  endtask
  // Clear with words stored, then reuse
  task t_clear;
    put(4'h3);
    put(4'h7);
    repeat (20) @(posedge clk_in);
    clear_req_in <= 1'b1;
    @(posedge clk_in);
    clear_req_in <= 1'b0;
    // Enable and level follow the busy flag one edge later
    repeat (2) @(negedge clk_in);
    chk("clear_pin", {3'h0, mc, oen}, 5'h03);
    chk("level_clr", level_out, 5'h00);
    while (clear_busy_out !== 1'b0) @(negedge clk_in);
    chk("flags_clr", {3'h0, ir, ov}, 5'h02);
    chk("rd_keep", {1'b0, rd_data_out}, 5'h0A);
    put(4'hC);
    get(4'hC);
  endtask
  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk_in);
    mismatches++;
    give_verdict();
  end
  initial begin
    {rst_in, wr_valid_in, rd_ready_in, clear_req_in, wr_data_in} = 8'h80;
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    t_fill_drain();
    t_clear();
    give_verdict();
  end
endmodule
bind ebf_host ebf_host_properties chk_u (.clk_in(clk_in), .rst_in(rst_in),
  .master_clear_out(master_clear_out), .push_strobe_out(push_strobe_out),
  .pop_strobe_out(pop_strobe_out), .clear_busy_out(clear_busy_out),
  .level_out(level_out));
`default_nettype wire
